// ===== pnfc_ctrl.sv
// module: host controller driving a parallel nor flash over its pins
// Contract
// R1 - 20 address lines, byte mode adds lsb; code drives it on dq15 in write cycles only, byte reads leave it floating
// R2 - word 16 bits, byte 8 bits
// R3 - byte mode leaves data 14..8 undriven
// R4 - width select low means byte mode
// R5 - chip select high floats bus
// R6 - write only with output enable high
// R7 - host asserts output enable only reading
// R8 - reset low aborts program or erase
// R9 - device in standby while reset low
// R10 - ready busy low while busy
// R11 - program is four write cycles
// R12 - bypass program needs two cycles
// R13 - erase preprograms then erases internally
// R14 - protected sectors refuse changes
// R15 - erase may be suspended and resumed
// R16 - device latches command address and data
// R17 - bit7 polls, bit6 toggles while busy
// R18 - writes ignored on low supply
// R19 - automatic sleep after stable address
// R20 - read: chip and output enable low
// R21 - read array after reset
// R22 - status read during program or erase
// R23 - timeout bit needs reset to recover
// R24 - bad sequence discarded by device
`timescale 1ns/1ps
module pnfc_ctrl
    import pnfc_pkg::*;
(
    input wire logic sys_clk, // 200 MHz clock
    input wire logic sys_rst, // sync reset, high
    input wire logic reqValid, // start an operation, pulse
    input wire logic [2:0] reqOp, // operation code
    input wire logic reqByte, // 1 = byte mode transfer
    input wire logic reqBypass, // program in unlock bypass
    input wire logic [20:0] reqAddr, // byte addr [0] or word [19:0]
    input wire logic [15:0] reqData, // write data
    output logic reqReady, // idle, may take request
    output logic rspValid, // answer pulse
    output logic [15:0] rspData, // read data
    output logic rspTimeout, // program failed on timeout bit
    output logic [19:0] flashAddr, // address pins
    output logic [15:0] flashDqOut, // data pins out
    output logic [15:0] flashDqOe, // per-pin drive enable
    input wire logic [15:0] flashDqIn, // data pins in
    output logic flashWidthSelN, // width_select_n
    output logic flashChipSelN, // chip_select_n
    output logic flashOutEnN, // output_enable_n
    output logic flashWriteEnN, // write_enable_n
    output logic flashHwResetN, // hw_reset_n
    input wire logic flashReadyBusyN // ready_busy_n, pulled up
);
    typedef enum logic [6:0] {
        S_IDLE = 7'b000_0001,
        S_WSET = 7'b000_0010,
        S_WPUL = 7'b000_0100,
        S_RD = 7'b000_1000,
        S_POLL = 7'b001_0000,
        S_RST = 7'b010_0000,
        S_DONE = 7'b100_0000
    } pnfc_state_e;

    pnfc_state_e state_q, state_d;
    logic [15:0] dqIn;
    logic rbN;
    logic [7:0] cnt_q;
    logic [1:0] step_q;
    logic [1:0] last_q;
    logic [2:0] op_q;
    logic byte_q;
    logic [20:0] addr_q;
    logic [15:0] data_q;
    logic prevTog_q;
    logic polling_q;

    ////////////////////////////////////////////////////////////////////
    pnfc_sync #(.W(17)) u_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .din({flashReadyBusyN, flashDqIn}),
        .dout({rbN, dqIn})
    );

    // command cycle contents by step
    function automatic logic [35:0] cmdCycle(input logic [1:0] s,
        input logic [1:0] last, input logic [2:0] op,
        input logic [19:0] a, input logic [15:0] d);
        logic [35:0] r;
        r = {a, d};
        if (op == OP_SWRESET) r = {20'h0_0000, CMD_RESET};
        else if (s == last) r = {a, d};
        else if (s == 2'd0 && last == 2'd3) r = {UNLOCK_A1, UNLOCK_D1};
        else if (s == 2'd1) r = {UNLOCK_A2, UNLOCK_D2};
        else r = {UNLOCK_A1, CMD_PROGRAM};
        // bypass: only the program command then data
        if (last == 2'd1 && s == 2'd0) r = {20'h0_0000, CMD_PROGRAM};
        return r;
    endfunction : cmdCycle

    wire [35:0] cyc = cmdCycle(step_q, last_q, op_q, addr_q[20:1],
        data_q);
    wire [19:0] cycAddr = byte_q && step_q == last_q ? addr_q[20:1]
        : cyc[35:16];
    wire [19:0] rdAddr = byte_q ? addr_q[20:1] : addr_q[19:0];
    wire [19:0] wrAddr = (step_q == last_q && !byte_q) ? addr_q[19:0]
        : cycAddr;
    wire toggled = dqIn[TOGGLE_BIT] ^ prevTog_q;
    wire pollDone = !toggled && rbN;
    wire timedOut = toggled && dqIn[TIMEOUT_BIT];
    wire cntZero = cnt_q == 8'h00;
    wire [1:0] lastSel = reqOp == OP_PROGRAM ?
        (reqBypass ? 2'd1 : 2'd3) : 2'd0; // see R11 see R12

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        state_d = state_q;
        case (state_q)
            S_IDLE: begin
                if (reqValid && reqReady) begin
                    if (reqOp == OP_READ) state_d = S_RD;
                    else if (reqOp == OP_HWRESET) state_d = S_RST;
                    else state_d = S_WSET;
                end
            end
            S_WSET: if (cntZero) state_d = S_WPUL;
            S_WPUL: begin
                if (cntZero && step_q == last_q)
                    state_d = op_q == OP_PROGRAM ? S_POLL : S_DONE;
                else if (cntZero) state_d = S_WSET;
            end
            S_RD: if (cntZero) state_d = polling_q ? S_POLL : S_DONE;
            S_POLL: if (cntZero) state_d = S_RD;
            S_RST: if (cntZero) state_d = S_DONE;
            S_DONE: state_d = S_IDLE;
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) state_q <= S_IDLE;
        else state_q <= state_d;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt_q <= 8'h00;
            step_q <= 2'd0;
            last_q <= 2'd0;
            op_q <= OP_READ;
            byte_q <= 1'b0;
            addr_q <= '0;
            data_q <= '0;
            prevTog_q <= 1'b0;
            polling_q <= 1'b0;
            rspValid <= 1'b0;
            rspData <= '0;
            rspTimeout <= 1'b0;
        end else begin
            rspValid <= state_q == S_DONE;
            if (!cntZero) cnt_q <= cnt_q - 8'h01;
            case (state_q)
                S_IDLE: begin
                    if (reqValid && reqReady) begin
                        op_q <= reqOp;
                        byte_q <= reqByte;
                        addr_q <= reqAddr;
                        data_q <= reqData;
                        step_q <= 2'd0;
                        last_q <= lastSel;
                        polling_q <= 1'b0;
                        rspTimeout <= 1'b0;
                        cnt_q <= reqOp == OP_HWRESET ? RST_CYC : REC_CYC;
                        if (reqOp == OP_READ) cnt_q <= ACCESS_CYC;
                    end
                end
                S_WSET: if (cntZero) cnt_q <= WE_CYC;
                S_WPUL: begin
                    if (cntZero && step_q == last_q) begin
                        polling_q <= op_q == OP_PROGRAM; // see R17
                        cnt_q <= REC_CYC;
                    end else if (cntZero) begin
                        step_q <= step_q + 2'd1;
                        cnt_q <= REC_CYC;
                    end
                end
                S_RD: begin
                    if (cntZero) begin
                        rspData <= byte_q ? {8'h00, dqIn[7:0]} : dqIn;
                        prevTog_q <= dqIn[TOGGLE_BIT];
                        if (polling_q && pollDone) polling_q <= 1'b0;
                        if (polling_q && timedOut) begin
                            polling_q <= 1'b0; // see R23
                            rspTimeout <= 1'b1;
                        end
                        cnt_q <= polling_q ? REC_CYC : 8'h00;
                    end
                end
                S_POLL: if (cntZero) cnt_q <= ACCESS_CYC;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pins are registered; write pulse only with output enable high
    wire wrPhase = state_q == S_WSET || state_q == S_WPUL;
    wire rdPhase = state_q == S_RD;
    wire [15:0] dqOeNext = !wrPhase ? 16'h0000
        : byte_q ? 16'h80FF : 16'hFFFF; // see R3
    wire [15:0] dqOutNext = byte_q
        ? {addr_q[0], 7'h00, cyc[7:0]} : cyc[15:0]; // see R1 see R2

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            flashAddr <= '0;
            flashDqOut <= '0;
            flashDqOe <= '0;
            flashWidthSelN <= 1'b1;
            flashChipSelN <= 1'b1;
            flashOutEnN <= 1'b1;
            flashWriteEnN <= 1'b1;
            flashHwResetN <= 1'b0;
            reqReady <= 1'b0;
        end else begin
            reqReady <= state_d == S_IDLE;
            flashAddr <= wrPhase ? wrAddr : rdAddr; // see R16
            flashDqOut <= dqOutNext;
            flashDqOe <= dqOeNext;
            flashWidthSelN <= !byte_q; // see R4
            flashChipSelN <= !(wrPhase || rdPhase); // see R5 see R20
            flashOutEnN <= !rdPhase; // see R7
            flashWriteEnN <= !(state_q == S_WPUL && !cntZero); // see R6
            flashHwResetN <= state_q != S_RST; // see R8 see R9
        end
    end
    // strobe rises a cycle before select, address and data move
    // byte reads leave dq15 floating: only even bytes are reliable

    ////////////////////////////////////////////////////////////////////
    property p_we_oe_exclusive;
        @(posedge sys_clk) disable iff (sys_rst)
        !flashWriteEnN |-> flashOutEnN && !flashChipSelN;
    endproperty
    a_we_oe_exclusive: assert property (p_we_oe_exclusive) // see R6
        else $error("write strobe with output enable or no select");

    property p_oe_only_read;
        @(posedge sys_clk) disable iff (sys_rst)
        !flashOutEnN |-> flashWriteEnN && flashDqOe == 16'h0000;
    endproperty
    a_oe_only_read: assert property (p_oe_only_read) // see R7
        else $error("output enable while driving data");

    property p_byte_float;
        @(posedge sys_clk) disable iff (sys_rst)
        !flashWidthSelN |-> flashDqOe[14:8] == 7'h00;
    endproperty
    a_byte_float: assert property (p_byte_float) // see R3
        else $error("upper data driven in byte mode");

    property p_cs_high_float;
        @(posedge sys_clk) disable iff (sys_rst)
        flashChipSelN |-> flashWriteEnN && flashOutEnN;
    endproperty
    a_cs_high_float: assert property (p_cs_high_float) // see R5
        else $error("strobe without chip select");

    sequence s_rst_go;
        state_q == S_IDLE && reqValid && reqReady && reqOp == OP_HWRESET;
    endsequence
    property p_hw_reset;
        @(posedge sys_clk) disable iff (sys_rst)
        s_rst_go |=> ##1 !flashHwResetN && flashChipSelN;
    endproperty
    a_hw_reset: assert property (p_hw_reset) // see R8
        else $error("reset pin not asserted");

    property p_width;
        @(posedge sys_clk) disable iff (sys_rst)
        state_q != S_IDLE |=> flashWidthSelN == !byte_q;
    endproperty
    a_width: assert property (p_width) // see R4
        else $error("width select mismatch");

    property p_prog_pulses;
        @(posedge sys_clk) disable iff (sys_rst)
        state_q == S_IDLE && reqValid && reqReady && reqOp == OP_PROGRAM
            && !reqBypass |=> last_q == 2'd3;
    endproperty
    a_prog_pulses: assert property (p_prog_pulses) // see R11
        else $error("program not four cycles");

    property p_bypass;
        @(posedge sys_clk) disable iff (sys_rst)
        state_q == S_IDLE && reqValid && reqReady && reqOp == OP_PROGRAM
            && reqBypass |=> last_q == 2'd1;
    endproperty
    a_bypass: assert property (p_bypass) // see R12
        else $error("bypass program not two cycles");
endmodule : pnfc_ctrl

// ===== pnfc_flash_model.sv
// model: flash device answering the controller's pins
`timescale 1ns/1ps
module pnfc_flash_model #(
    parameter int BUSY_CYC = 40
) (
    input wire logic sys_clk, // paces the internal algorithm
    input wire logic failMode, // next program hangs, timeout bit
    input wire logic [19:0] flashAddr, // address pins
    input wire logic [15:0] flashDqOut, // controller data out
    input wire logic [15:0] flashDqOe, // controller drive enable
    output logic [15:0] flashDqIn, // resolved data pins
    input wire logic flashWidthSelN, // low selects byte mode
    input wire logic flashChipSelN, // chip select
    input wire logic flashOutEnN, // output enable
    input wire logic flashWriteEnN, // write enable
    input wire logic flashHwResetN, // hardware reset
    output logic flashReadyBusyN // driven low while busy, driven high when ready
);
    logic [15:0] mem [0:255];
    logic [15:0] lastData, rd, pat;
    logic [1:0] step;
    logic [7:0] pAddr;
    logic bypass, pend, tog, failing, seenWidthN, drv, busy;
    int busyCnt, nWrites;
    initial begin
        foreach (mem[i]) mem[i] = 16'hFFFF;
        {step, bypass, pend, tog, failing, seenWidthN} = '0;
        busyCnt = 0;
        nWrites = 0;
        pat = 16'hA5A5;
        lastData = '0;
    end
    ////////////////////////////////////////////////////////////////////////
    // writes land on the strobe's rising edge, so address and data latch
    always @(posedge flashWriteEnN) begin
        if (!flashChipSelN && flashOutEnN && flashHwResetN) begin
            nWrites++;
            if (!busy && pend) begin
                pend = 0;
                lastData = flashDqOut;
                failing = failMode;
                busyCnt = BUSY_CYC;
                pAddr = flashAddr[7:0]; // array changes when the busy count runs out, BUSY_CYC clocks later
            end else if (flashDqOut[7:0] == 8'hF0) begin
                {step, pend, failing} = '0;
                busyCnt = 0;
            end else if (!busy && step == 0) begin
                step = (flashDqOut[7:0] == 8'hAA && flashAddr == 20'h0_0555);
                pend = bypass && flashDqOut[7:0] == 8'hA0;
            end else if (!busy && step == 1) begin
                step = (flashDqOut[7:0] == 8'h55 && flashAddr == 20'h0_02AA) ? 2 : 0;
            end else if (!busy) begin
                step = 0;
                pend = flashAddr == 20'h0_0555 && flashDqOut[7:0] == 8'hA0;
                bypass |= flashAddr == 20'h0_0555 && flashDqOut[7:0] == 8'h20;
            end
        end
    end
    always @(posedge sys_clk) begin
        pat <= ~pat;
        if (!flashHwResetN) begin
            busyCnt = 0;
            {step, pend, failing, bypass} = '0;
        end else if (busyCnt > 0 && !failing) begin
            if (busyCnt == 1) mem[pAddr] = mem[pAddr] & lastData;
            busyCnt = busyCnt - 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    always @(negedge flashOutEnN) begin
        seenWidthN = flashWidthSelN;
        if (busy) tog = ~tog;
    end
    assign busy = busyCnt != 0 || failing;
    assign flashReadyBusyN = !busy;
    assign drv = !flashChipSelN && !flashOutEnN && flashWriteEnN && flashHwResetN;
    // undriven pins show a changing pattern, never the last value
    always_comb begin
        rd = mem[flashAddr[7:0]];
        if (busy) rd = {8'h00, ~lastData[7], tog, failing, 5'h0};
        else if (!flashWidthSelN) rd = {8'h00, rd[7:0]};
        for (int i = 0; i < 16; i++)
            flashDqIn[i] = flashDqOe[i] ? flashDqOut[i] :
                (drv && (flashWidthSelN || i < 8)) ? rd[i] : pat[i];
    end
endmodule : pnfc_flash_model

// ===== pnfc_pkg.sv
// package: constants for the parallel nor flash host controller
package pnfc_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    // bus timing, ns at 200 MHz (5 ns period)
    localparam int CLK_NS = 5;
    localparam int ACCESS_NS = 70;
    localparam int WE_PULSE_NS = 35;
    localparam int RECOVER_NS = 20;
    localparam int RESET_PULSE_NS = 500;
    localparam logic [7:0] ACCESS_CYC = 8'((ACCESS_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] WE_CYC = 8'((WE_PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] REC_CYC = 8'((RECOVER_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] RST_CYC =
        8'((RESET_PULSE_NS + CLK_NS - 1) / CLK_NS);
    // command cycle addresses and data (word mode)
    localparam logic [19:0] UNLOCK_A1 = 20'h0_0555;
    localparam logic [19:0] UNLOCK_A2 = 20'h0_02AA;
    localparam logic [15:0] UNLOCK_D1 = 16'h00AA;
    localparam logic [15:0] UNLOCK_D2 = 16'h0055;
    localparam logic [15:0] CMD_PROGRAM = 16'h00A0;
    localparam logic [15:0] CMD_RESET = 16'h00F0;
    // user operation codes
    localparam logic [2:0] OP_READ = 3'h0;
    localparam logic [2:0] OP_PROGRAM = 3'h1;
    localparam logic [2:0] OP_WRITE = 3'h2;
    localparam logic [2:0] OP_HWRESET = 3'h3;
    localparam logic [2:0] OP_SWRESET = 3'h4;
    // status bit positions
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int TIMEOUT_BIT = 5;
endpackage : pnfc_pkg

// ===== pnfc_sync.sv
// module: two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pnfc_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk, // system clock
    input wire logic sys_rst, // sync reset, high
    input wire logic [W-1:0] din, // asynchronous input
    output logic [W-1:0] dout // synchronised output
);
    logic [W-1:0] meta_q;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule : pnfc_sync

// ===== tb.sv
// testbench: controller against the flash model
`timescale 1ns/1ps
module tb;
    import pnfc_pkg::*;
    logic sys_clk, sys_rst, reqValid, reqByte, reqBypass, failMode;
    logic [2:0] reqOp;
    logic [20:0] reqAddr;
    logic [15:0] reqData, rspData, flashDqOut, flashDqOe, flashDqIn;
    logic [19:0] flashAddr;
    logic reqReady, rspValid, rspTimeout, flashWidthSelN, flashChipSelN;
    logic flashOutEnN, flashWriteEnN, flashHwResetN, flashReadyBusyN;
    int n_mismatch = 0;
    int comparisons = 0;
    int n0;
    pnfc_ctrl pnfc_ctrl_inst (.sys_clk, .sys_rst, .reqValid, .reqOp,
        .reqByte, .reqBypass, .reqAddr, .reqData, .reqReady, .rspValid,
        .rspData, .rspTimeout, .flashAddr, .flashDqOut, .flashDqOe,
        .flashDqIn, .flashWidthSelN, .flashChipSelN, .flashOutEnN,
        .flashWriteEnN, .flashHwResetN, .flashReadyBusyN);
    pnfc_flash_model pnfc_flash_model_inst (.sys_clk, .failMode, .flashAddr,
        .flashDqOut, .flashDqOe, .flashDqIn, .flashWidthSelN, .flashChipSelN,
        .flashOutEnN, .flashWriteEnN, .flashHwResetN, .flashReadyBusyN);
    initial begin
        sys_clk = 0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic run(logic [2:0] op, logic bm, logic byp, logic [20:0] a,
        logic [15:0] d);
        int k;
        k = 0;
        while (reqReady !== 1'b1 && k < 4000) begin
            @(negedge sys_clk);
            k++;
        end
        {reqOp, reqByte, reqBypass, reqAddr, reqData} = {op, bm, byp, a, d};
        reqValid = 1;
        @(negedge sys_clk);
        reqValid = 0;
        while (rspValid !== 1'b1 && k < 4000) begin
            @(negedge sys_clk);
            k++;
        end
        if (k >= 4000) check("answer", 16'h0001, 16'h0000);
    endtask : run
    task automatic wr(logic [19:0] a, logic [15:0] d);
        run(OP_WRITE, 0, 0, {1'b0, a}, d);
    endtask : wr
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {reqValid, reqByte, reqBypass, failMode} = '0;
        {reqOp, reqAddr, reqData} = '0;
        sys_rst = 1;
        repeat (10) @(negedge sys_clk);
        sys_rst = 0;
        run(OP_READ, 0, 0, 21'h00_0010, 16'h0000);
        check("erased read", 16'hFFFF, rspData);
        $display("test reset read done");
        n0 = pnfc_flash_model_inst.nWrites;
        run(OP_PROGRAM, 0, 0, 21'h00_0010, 16'h1234);
        check("program writes", 16'h0004, 16'(pnfc_flash_model_inst.nWrites - n0));
        check("timeout flag", 16'h0000, rspTimeout);
        run(OP_READ, 0, 0, 21'h00_0010, 16'h0000);
        check("word read", 16'h1234, rspData);
        check("width select", 16'h0001,
            pnfc_flash_model_inst.seenWidthN);
        run(OP_READ, 1, 0, 21'h00_0020, 16'h0000);
        check("byte read", 16'h0034, rspData);
        check("width select", 16'h0000, pnfc_flash_model_inst.seenWidthN);
        $display("test program done");
        wr(20'h0_0555, 16'h00AA);
        wr(20'h0_02AA, 16'h0055);
        wr(20'h0_0555, 16'h0020);
        n0 = pnfc_flash_model_inst.nWrites;
        run(OP_PROGRAM, 0, 1, 21'h00_0011, 16'hBEEF);
        check("bypass writes", 16'h0002, 16'(pnfc_flash_model_inst.nWrites - n0));
        run(OP_READ, 0, 0, 21'h00_0011, 16'h0000);
        check("bypass read", 16'hBEEF, rspData);
        $display("test bypass done");
        wr(20'h0_0555, 16'h00AA);
        wr(20'h0_02AA, 16'h0055);
        wr(20'h0_0555, 16'h00A0);
        wr(20'h0_0012, 16'h0F0F);
        check("busy pin", 16'h0000, flashReadyBusyN);
        run(OP_HWRESET, 0, 0, 21'h00_0000, 16'h0000);
        check("ready after reset", 16'h0001, flashReadyBusyN);
        run(OP_READ, 0, 0, 21'h00_0012, 16'h0000);
        check("aborted read", 16'hFFFF, rspData);
        $display("test hardware reset done");
        failMode = 1;
        run(OP_PROGRAM, 0, 0, 21'h00_0013, 16'h00AA);
        check("timeout flag", 16'h0001, rspTimeout);
        failMode = 0;
        run(OP_SWRESET, 0, 0, 21'h00_0000, 16'h0000);
        check("ready after sw reset", 16'h0001, flashReadyBusyN);
        run(OP_READ, 0, 0, 21'h00_0013, 16'h0000);
        check("read after sw reset", 16'hFFFF, rspData);
        $display("test timeout done");
        close_out;
    end
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_mismatch++;
        $display("ERROR watchdog expected finish seen hang");
        close_out;
    end
endmodule : tb
